// >>> verilog/tag_ctrl_pkg.sv
// Purpose: shared constants for the tag controller
// Assumes: 20 MHz system clock standing in for the on-board time-base oscillator
// Notes: mode codes arrive first bit first on the programming-data pad
package tag_ctrl_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned BIT_RATE_HZ = 70_000;
    // half a bit period in clock cycles, rounded down
    localparam int unsigned HALF_BIT_CYC = CLK_HZ / (2 * BIT_RATE_HZ);
    localparam int unsigned SLEEP_MS = 100;
    localparam int unsigned SLEEP_CYC = CLK_HZ / 1000 * SLEEP_MS;
    localparam int unsigned MEM_BITS = 154;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CODE_W = 10;
    localparam logic [9:0] CODE_ERASE = 10'h1d4;
    localparam logic [9:0] CODE_PROGRAM = 10'h1d2;
    localparam logic [9:0] CODE_READ = 10'h1d6;
    localparam logic [7:0] LAST_ADDR = 8'h99;
    localparam logic [7:0] HALF_BIT_CNT = 8'(HALF_BIT_CYC - 1);
    typedef enum logic [2:0] {
        ST_SEND = 3'b000,
        ST_SLEEP = 3'b001,
        ST_CODE = 3'b010,
        ST_ERASE = 3'b011,
        ST_PROG = 3'b100,
        ST_READ = 3'b101
    } ctrl_state_e;
endpackage

// >>> verilog/tag_ctrl.sv
// Purpose: controller logic of a passive contactless tag
// Assumes: i_rst is the power-on reset, held until supply is good
// Notes: pad inputs are synchronised; memory is an internal flag array
`timescale 1ns/1ns
module tag_ctrl #(
    parameter int unsigned SLEEP_CYCLES = tag_ctrl_pkg::SLEEP_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_prog_clk_pad,
    input wire logic i_prog_data_pad,
    input wire logic i_high_program_voltage,
    output logic o_mod_switch,
    output logic o_prog_data_pad,
    output logic o_prog_data_pad_oe
);

    ////////////////////////////////////////////////////////////////////////
    // pad synchronisers
    logic [1:0] clk_sync_r;
    logic [1:0] data_sync_r;
    logic [1:0] hv_sync_r;
    logic clk_prev_r;
    logic clk_rise;
    logic clk_fall;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            clk_sync_r <= 2'h0;
            data_sync_r <= 2'h0;
            hv_sync_r <= 2'h0;
            clk_prev_r <= 1'b0;
        end else begin
            clk_sync_r <= {clk_sync_r[0], i_prog_clk_pad};
            data_sync_r <= {data_sync_r[0], i_prog_data_pad};
            hv_sync_r <= {hv_sync_r[0], i_high_program_voltage};
            clk_prev_r <= clk_sync_r[1];
        end
    end

    assign clk_rise = clk_sync_r[1] && !clk_prev_r;
    assign clk_fall = !clk_sync_r[1] && clk_prev_r;

    ////////////////////////////////////////////////////////////////////////
    // state
    tag_ctrl_pkg::ctrl_state_e state_r;
    logic [tag_ctrl_pkg::MEM_BITS-1:0] mem_r;
    logic [tag_ctrl_pkg::ADDR_W-1:0] addr_r;
    logic [tag_ctrl_pkg::CODE_W-1:0] code_r;
    logic [3:0] code_cnt_r;
    logic [7:0] half_cnt_r;
    logic half_r;
    logic [31:0] sleep_cnt_r;
    logic code_done;
    logic [tag_ctrl_pkg::CODE_W-1:0] code_nxt;
    logic half_tick;
    logic hv_seen_r;
    logic mem_bit;
    logic rd_armed_r;

    assign code_nxt = {code_r[tag_ctrl_pkg::CODE_W-2:0], data_sync_r[1]};
    assign code_done = clk_rise && (code_cnt_r == 4'(tag_ctrl_pkg::CODE_W - 1));
    assign half_tick = (half_cnt_r == tag_ctrl_pkg::HALF_BIT_CNT);
    assign mem_bit = mem_r[addr_r];

    // half-bit divider; resets whenever not transmitting
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            half_cnt_r <= 8'h00;
        end else if (state_r != tag_ctrl_pkg::ST_SEND || half_tick) begin
            half_cnt_r <= 8'h00;
        end else begin
            half_cnt_r <= half_cnt_r + 8'h01;
        end
    end

    // mode code shift register; any rising edge outside a function counts
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            code_r <= 10'h000;
            code_cnt_r <= 4'h0;
        end else if (state_r inside {tag_ctrl_pkg::ST_SEND, tag_ctrl_pkg::ST_SLEEP,
                                     tag_ctrl_pkg::ST_CODE}) begin
            if (code_done) begin
                code_cnt_r <= 4'h0;
            end else if (clk_rise) begin
                code_r <= code_nxt;
                code_cnt_r <= code_cnt_r + 4'h1;
            end
        end else begin
            code_cnt_r <= 4'h0;
        end
    end

    // high voltage seen since last pad clock rising edge; used only for program exit, the write uses hv_sync_r directly
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            hv_seen_r <= 1'b0;
        end else if (clk_rise) begin
            hv_seen_r <= 1'b0;
        end else if (hv_sync_r[1] && !clk_sync_r[1]) begin
            hv_seen_r <= 1'b1;
        end
    end

    // read entry lands inside the last code clock; only the next rising edge starts bit 0
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rd_armed_r <= 1'b0;
        end else if (state_r != tag_ctrl_pkg::ST_READ) begin
            rd_armed_r <= 1'b0;
        end else if (clk_rise) begin
            rd_armed_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequencer
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= tag_ctrl_pkg::ST_SEND;
            addr_r <= 8'h00;
            half_r <= 1'b0;
            sleep_cnt_r <= 32'h0;
        end else begin
            case (state_r)
                tag_ctrl_pkg::ST_SEND: begin
                    if (clk_rise) begin
                        state_r <= tag_ctrl_pkg::ST_CODE;
                        addr_r <= 8'h00;
                        half_r <= 1'b0;
                    end else if (half_tick) begin
                        half_r <= !half_r;
                        if (half_r) begin
                            if (addr_r == tag_ctrl_pkg::LAST_ADDR) begin
                                state_r <= tag_ctrl_pkg::ST_SLEEP;
                                addr_r <= 8'h00;
                                sleep_cnt_r <= 32'h0;
                            end else begin
                                addr_r <= addr_r + 8'h01;
                            end
                        end
                    end
                end
                tag_ctrl_pkg::ST_SLEEP: begin
                    if (clk_rise) begin
                        state_r <= tag_ctrl_pkg::ST_CODE;
                    end else if (sleep_cnt_r == SLEEP_CYCLES - 1) begin
                        state_r <= tag_ctrl_pkg::ST_SEND;
                        addr_r <= 8'h00;
                        half_r <= 1'b0;
                    end else begin
                        sleep_cnt_r <= sleep_cnt_r + 32'h1;
                    end
                end
                tag_ctrl_pkg::ST_CODE: begin
                    addr_r <= 8'h00;
                    if (code_done) begin
                        case (code_nxt)
                            tag_ctrl_pkg::CODE_ERASE: state_r <= tag_ctrl_pkg::ST_ERASE;
                            tag_ctrl_pkg::CODE_PROGRAM: state_r <= tag_ctrl_pkg::ST_PROG;
                            tag_ctrl_pkg::CODE_READ: state_r <= tag_ctrl_pkg::ST_READ;
                            default: state_r <= tag_ctrl_pkg::ST_CODE;
                        endcase
                    end
                end
                tag_ctrl_pkg::ST_ERASE: begin
                    // erase is done in one cycle; next clock returns to code entry
                    if (clk_rise) begin
                        state_r <= tag_ctrl_pkg::ST_CODE;
                    end
                end
                tag_ctrl_pkg::ST_PROG,
                tag_ctrl_pkg::ST_READ: begin
                    // first read clock only arms the pad driver, so bit 0 is not skipped
                    if (clk_rise && (state_r == tag_ctrl_pkg::ST_PROG || rd_armed_r)) begin
                        if ((state_r == tag_ctrl_pkg::ST_PROG && !hv_seen_r) ||
                            addr_r == tag_ctrl_pkg::LAST_ADDR) begin
                            state_r <= tag_ctrl_pkg::ST_CODE;
                        end
                        addr_r <= (addr_r == tag_ctrl_pkg::LAST_ADDR) ? 8'h00
                                                                   : addr_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= tag_ctrl_pkg::ST_SEND;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory array
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mem_r <= '1;
        end else if (state_r == tag_ctrl_pkg::ST_CODE && code_done &&
                     code_nxt == tag_ctrl_pkg::CODE_ERASE) begin
            mem_r <= '1;
        end else if (state_r == tag_ctrl_pkg::ST_PROG && hv_sync_r[1] && !clk_sync_r[1]) begin
            mem_r[addr_r] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_mod_switch <= 1'b0;
        end else if (state_r == tag_ctrl_pkg::ST_SEND) begin
            // first half carries the bit, second half its inverse
            o_mod_switch <= half_r ? !mem_bit : mem_bit;
        end else if (state_r == tag_ctrl_pkg::ST_SLEEP) begin
            o_mod_switch <= 1'b1;
        end else begin
            o_mod_switch <= 1'b0;
        end
    end

    // drive only while pad clock is high; programmer releases then
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_prog_data_pad <= 1'b0;
            o_prog_data_pad_oe <= 1'b0;
        end else begin
            o_prog_data_pad <= mem_bit;
            o_prog_data_pad_oe <= (state_r == tag_ctrl_pkg::ST_READ) && rd_armed_r
                                  && clk_sync_r[1] && !clk_fall;
        end
    end

endmodule // tag_ctrl

// >>> verif/prog_model.sv
// Purpose: contact programmer model driving the pad clock, data pad and high voltage
// Assumes: HALF mclk cycles of pad clock high, HALF plus 4 cycles low
// Notes: the data pad has a pull-down, so a released undriven pad reads low
`timescale 1ns/1ns
module prog_model #(
    parameter int unsigned HALF = 24
) (
    input wire logic i_mclk,
    input wire logic i_dev_data,
    input wire logic i_dev_oe,
    output logic o_clk_pad,
    output logic o_data_pad,
    output logic o_hv
);
    logic drv_v = 1'b0;
    logic drv_en = 1'b1;
    assign o_data_pad = i_dev_oe ? i_dev_data : drv_en & drv_v;
    initial begin
        o_clk_pad = 1'b0;
        o_hv = 1'b0;
    end
    ////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask
    task automatic pad_cycle(input logic d, input logic hv, input logic rel, output logic got);
        drv_v = d;
        drv_en = 1'b1;
        o_hv = hv;
        tick(HALF);
        // hv drops before the edge; hv_seen_r still holds it, so the edge does not end the function
        o_hv = 1'b0;
        tick(4);
        drv_en = ~rel;
        o_clk_pad = 1'b1;
        tick(HALF);
        got = o_data_pad;
        o_clk_pad = 1'b0;
    endtask
    task automatic send_code(input logic [9:0] code);
        logic g;
        for (int i = 9; i >= 0; i--)
            pad_cycle(code[i], 1'b0, 1'b0, g);
    endtask
endmodule // prog_model

// >>> verif/tag_ctrl_asserts.sv
// Purpose: port-level checks of the tag controller
// Assumes: switch run checks stop once the pad clock has risen
// Notes: level run lengths of the switch are counted in helper flops
`timescale 1ns/1ns
module tag_ctrl_asserts #(
    parameter int unsigned SLEEP_CYCLES = 50
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_prog_clk_pad,
    input wire logic i_prog_data_pad,
    input wire logic i_high_program_voltage,
    input wire logic o_mod_switch,
    input wire logic o_prog_data_pad,
    input wire logic o_prog_data_pad_oe
);
    localparam int unsigned H = tag_ctrl_pkg::HALF_BIT_CYC;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    int unsigned run_r;
    logic sw_r;
    logic started_r;
    logic prog_r;
    ////////////////////////////////////////
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            run_r <= 0;
            sw_r <= 1'b0;
            started_r <= 1'b0;
            prog_r <= 1'b0;
        end else begin
            run_r <= (o_mod_switch != sw_r) ? 1 : run_r + 1;
            sw_r <= o_mod_switch;
            // first high run after reset may be trimmed, so start at first fall
            started_r <= started_r | (sw_r & ~o_mod_switch);
            prog_r <= prog_r | i_prog_clk_pad;
        end
    end
    ////////////////////////////////////////
    property p_low_run;
        o_mod_switch && !sw_r && started_r && !prog_r |-> run_r == H || run_r == 2 * H;
    endproperty
    a_low_run: assert property (p_low_run) else $error("bad low run");
    property p_high_run;
        !o_mod_switch && sw_r && started_r && !prog_r |-> run_r == H || run_r == 2 * H
            || run_r == SLEEP_CYCLES + H || run_r == SLEEP_CYCLES + 2 * H;
    endproperty
    a_high_run: assert property (p_high_run) else $error("bad high run");
    property p_stuck; started_r && !prog_r |-> run_r <= SLEEP_CYCLES + 3 * H; endproperty
    a_stuck: assert property (p_stuck) else $error("switch stuck");
    property p_oe_clk; !i_prog_clk_pad [*6] |-> !o_prog_data_pad_oe; endproperty
    a_oe_clk: assert property (p_oe_clk) else $error("pad driven while clock low");
    property p_idle_oe; !prog_r |-> !o_prog_data_pad_oe; endproperty
    a_idle_oe: assert property (p_idle_oe) else $error("pad driven before code");
    property p_read_hold; o_prog_data_pad_oe [*5] |-> $stable(o_prog_data_pad); endproperty
    a_read_hold: assert property (p_read_hold) else $error("read bit moved");
    property p_rst_quiet; $fell(i_rst) |-> !o_mod_switch && !o_prog_data_pad_oe; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("output during reset");
    property p_start_tx; $fell(i_rst) |-> ##[1:4] o_mod_switch; endproperty
    a_start_tx: assert property (p_start_tx) else $error("no start of send");
    c_sleep: cover property (started_r && !o_mod_switch && sw_r && run_r > 2 * H);
    c_read: cover property (o_prog_data_pad_oe && !o_prog_data_pad);
    c_hv: cover property (i_high_program_voltage && !i_prog_clk_pad && !i_prog_data_pad);
endmodule // tag_ctrl_asserts
bind tag_ctrl tag_ctrl_asserts #(.SLEEP_CYCLES(SLEEP_CYCLES)) chk (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_prog_clk_pad(i_prog_clk_pad),
    .i_prog_data_pad(i_prog_data_pad), .i_high_program_voltage(i_high_program_voltage),
    .o_mod_switch(o_mod_switch), .o_prog_data_pad(o_prog_data_pad),
    .o_prog_data_pad_oe(o_prog_data_pad_oe));

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the tag controller
// Assumes: sleep shortened to 50 cycles; memory is all ones after reset
// Notes: programmer model drives pads; reset twice stands for power cycling
`timescale 1ns/1ns
module tb_top;
    localparam int unsigned SLEEP = 50;
    localparam int unsigned H = tag_ctrl_pkg::HALF_BIT_CYC;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic clk_pad, data_pad, hv, sw, dq, oe;
    int mismatches = 0;
    int n_tests = 0;
    always #25 i_mclk = ~i_mclk;
    tag_ctrl #(.SLEEP_CYCLES(SLEEP)) dut (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_prog_clk_pad(clk_pad), .i_prog_data_pad(data_pad), .i_high_program_voltage(hv),
        .o_mod_switch(sw), .o_prog_data_pad(dq), .o_prog_data_pad_oe(oe));
    prog_model #(.HALF(24)) pm (.i_mclk(i_mclk), .i_dev_data(dq), .i_dev_oe(oe),
        .o_clk_pad(clk_pad), .o_data_pad(data_pad), .o_hv(hv));
    ////////////////////////////////////////
    task automatic chk(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask
    task automatic summarize();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic power_up();
        i_rst = 1'b1;
        pm.tick(20);
        i_rst = 1'b0;
    endtask
    task automatic t_transmit();
        int w;
        w = 0;
        while (sw !== 1'b1 && w < 10) begin
            pm.tick(1);
            w++;
        end
        for (int b = 0; b < tag_ctrl_pkg::MEM_BITS; b++) begin
            pm.tick(H / 2);
            chk(sw, 1'b1, "first half");
            pm.tick(H);
            chk(sw, 1'b0, "second half");
            pm.tick(H / 2);
        end
        pm.tick(SLEEP / 2);
        chk(sw, 1'b1, "sleep");
        // just before and after the middle of bit 0: only a full sleep lands both
        pm.tick(SLEEP / 2 + H - 4);
        chk(sw, 1'b1, "restart bit 0 first half");
        pm.tick(8);
        chk(sw, 1'b0, "restart bit 0");
    endtask
    task automatic read_all(input int nz);
        logic g;
        pm.send_code(tag_ctrl_pkg::CODE_READ);
        for (int b = 0; b < tag_ctrl_pkg::MEM_BITS; b++) begin
            pm.pad_cycle(1'b0, 1'b0, 1'b1, g);
            chk(g, logic'(b >= nz), "read bit");
        end
        // one more clock ends read mode; the device lets go and the pull-down wins
        pm.pad_cycle(1'b0, 1'b0, 1'b1, g);
        chk(g, 1'b0, "pad released after read");
    endtask
    task automatic t_program();
        logic g;
        pm.send_code(10'h3ff);
        pm.send_code(tag_ctrl_pkg::CODE_PROGRAM);
        for (int b = 0; b < 3; b++)
            pm.pad_cycle(1'b0, 1'b1, 1'b0, g);
        pm.pad_cycle(1'b0, 1'b0, 1'b0, g);
        read_all(3);
        pm.send_code(tag_ctrl_pkg::CODE_ERASE);
        pm.pad_cycle(1'b0, 1'b0, 1'b0, g);
        read_all(0);
    endtask
    ////////////////////////////////////////
    initial begin
        power_up();
        t_transmit();
        pm.tick(500);
        // power removed mid-frame, pads held low meanwhile
        power_up();
        t_program();
        summarize();
    end
    initial begin
        #(90000 * 50);
        mismatches++;
        summarize();
    end
endmodule // tb_top
